// >>> phf_drive_model.sv
`timescale 1ns/1ps
// ***
// Drive that takes one step per enabled cycle
// ***
module phf_drive_model (
  input  wire    clk_sys,
  input  wire    x_pulse_en,
  input  wire    y_pulse_en,
  output integer x_steps,
  output integer y_steps
);
  initial x_steps = 0;
  initial y_steps = 0;
  always @(posedge clk_sys) x_steps <= x_steps + x_pulse_en;
  always @(posedge clk_sys) y_steps <= y_steps + y_pulse_en;
endmodule

// >>> phf_halt_clear.v
`timescale 1ns/1ps
`include "phf_regs.vh"

module phf_halt_clear (
  // Clock and reset
  input  wire        clk_sys,
  input  wire        rst,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // Command inputs from the sequence program
  input  wire        halt_command,
  input  wire        fault_clear_command,
  input  wire        preset_command,
  input  wire [15:0] motion_channel_select,
  input  wire [15:0] inhibit_release_option,
  // Pulse enables from the motion generator
  input  wire        x_pulse_req,
  input  wire        y_pulse_req,
  // Axis outputs
  output reg         x_pulse_en,
  output reg         y_pulse_en,
  output reg         x_stopped_flag,
  output reg         y_stopped_flag,
  output reg         x_homed_flag,
  output reg         y_homed_flag,
  output reg         operand_fault_flag,
  output reg  [15:0] x_fault_code,
  output reg  [15:0] y_fault_code,
  output wire        irq
);

  // ****************************************************************
  // Command edge detection
  // ****************************************************************
  reg        halt_d_reg;
  reg        clr_d_reg;
  reg        prs_d_reg;
  reg        x_inhibit_reg;
  reg        y_inhibit_reg;
  reg  [2:0] irq_stat_reg;
  reg  [2:0] irq_mask_reg;
  reg        en_reg;

  // Rising edge of a command condition against its last sample
  function rise_of;
    input cur;
    input prev;
    begin
      rise_of = cur & ~prev;
    end
  endfunction

  wire halt_rise = rise_of(halt_command, halt_d_reg);
  wire clr_rise  = rise_of(fault_clear_command, clr_d_reg);
  wire prs_rise  = rise_of(preset_command, prs_d_reg);
  wire any_rise  = halt_rise | clr_rise | prs_rise;

  wire sel_x   = motion_channel_select == `PHF_CHAN_X;
  wire sel_y   = motion_channel_select == `PHF_CHAN_Y;
  wire sel_bad = ~sel_x & ~sel_y;
  wire go      = en_reg & any_rise;

  wire halt_x = go & halt_rise & sel_x;
  wire halt_y = go & halt_rise & sel_y;
  wire clr_x  = go & clr_rise & sel_x;
  wire clr_y  = go & clr_rise & sel_y;
  wire prs_x  = go & prs_rise & sel_x;
  wire prs_y  = go & prs_rise & sel_y;
  wire release_inh = inhibit_release_option != `PHF_INH_KEEP;

  // ****************************************************************
  // APB decode
  // ****************************************************************
  wire wr_acc = psel & penable & pwrite;
  wire known  = paddr == `PHF_CTRL_OFS || paddr == `PHF_CMD_OFS ||
                paddr == `PHF_STAT_OFS || paddr == `PHF_FAULT_OFS ||
                paddr == `PHF_IRQ_STAT_OFS || paddr == `PHF_IRQ_MASK_OFS;
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~known;

  wire opflt_clr = wr_acc & paddr == `PHF_CMD_OFS & pwdata[`PHF_CMD_OPFLT_CLR];
  wire irq_w1c   = wr_acc & paddr == `PHF_IRQ_STAT_OFS;
  wire [2:0] irq_ev = {go & sel_bad, clr_x | clr_y, halt_x | halt_y};

  assign irq = |(irq_stat_reg & irq_mask_reg);

  // ****************************************************************
  // Axis state
  // ****************************************************************
  always @(posedge clk_sys) begin
    if (rst) begin
      halt_d_reg         <= 1'b0;
      clr_d_reg          <= 1'b0;
      prs_d_reg          <= 1'b0;
      x_inhibit_reg      <= 1'b0;
      y_inhibit_reg      <= 1'b0;
      x_pulse_en         <= 1'b0;
      y_pulse_en         <= 1'b0;
      x_stopped_flag     <= 1'b0;
      y_stopped_flag     <= 1'b0;
      x_homed_flag       <= 1'b0;
      y_homed_flag       <= 1'b0;
      operand_fault_flag <= 1'b0;
      x_fault_code       <= `PHF_FAULT_NONE;
      y_fault_code       <= `PHF_FAULT_NONE;
      irq_stat_reg       <= 3'h0;
      irq_mask_reg       <= 3'h0;
      en_reg             <= `PHF_CTRL_EN_RST;
      prdata             <= 32'h00000000;
    end else begin
      halt_d_reg <= halt_command;
      clr_d_reg  <= fault_clear_command;
      prs_d_reg  <= preset_command;

      if (halt_x) begin
        x_stopped_flag <= 1'b1;
        x_fault_code   <= `PHF_HALT_CODE;
        x_inhibit_reg  <= 1'b1;
        x_homed_flag   <= 1'b0;
      end else if (clr_x) begin
        x_fault_code <= `PHF_FAULT_NONE;
        if (release_inh) begin
          x_inhibit_reg  <= 1'b0;
          x_stopped_flag <= 1'b0;
        end
      end else if (prs_x) begin
        x_homed_flag <= 1'b1;
      end

      if (halt_y) begin
        y_stopped_flag <= 1'b1;
        y_fault_code   <= `PHF_HALT_CODE;
        y_inhibit_reg  <= 1'b1;
        y_homed_flag   <= 1'b0;
      end else if (clr_y) begin
        y_fault_code <= `PHF_FAULT_NONE;
        if (release_inh) begin
          y_inhibit_reg  <= 1'b0;
          y_stopped_flag <= 1'b0;
        end
      end else if (prs_y) begin
        y_homed_flag <= 1'b1;
      end

      // Pulse gating: halt cuts output in the same edge it is seen
      x_pulse_en <= x_pulse_req & ~x_inhibit_reg & ~halt_x;
      y_pulse_en <= y_pulse_req & ~y_inhibit_reg & ~halt_y;

      // Set wins over software clear
      if (go & sel_bad)
        operand_fault_flag <= 1'b1;
      else if (opflt_clr)
        operand_fault_flag <= 1'b0;

      irq_stat_reg <= (irq_stat_reg & ~(irq_w1c ? pwdata[2:0] : 3'h0)) | irq_ev;

      if (wr_acc && paddr == `PHF_IRQ_MASK_OFS)
        irq_mask_reg <= pwdata[2:0];
      if (wr_acc && paddr == `PHF_CTRL_OFS)
        en_reg <= pwdata[0];

      // Read data registered in setup phase, valid in access phase
      if (psel & ~penable & ~pwrite) begin
        case (paddr)
          `PHF_CTRL_OFS:     prdata <= {31'h0, en_reg};
          `PHF_STAT_OFS:     prdata <= {25'h0, operand_fault_flag,
                                        y_homed_flag, y_inhibit_reg, y_stopped_flag,
                                        x_homed_flag, x_inhibit_reg, x_stopped_flag};
          `PHF_FAULT_OFS:    prdata <= {y_fault_code, x_fault_code};
          `PHF_IRQ_STAT_OFS: prdata <= {29'h0, irq_stat_reg};
          `PHF_IRQ_MASK_OFS: prdata <= {29'h0, irq_mask_reg};
          default:           prdata <= 32'h00000000;
        endcase
      end
    end
  end

endmodule

// >>> phf_halt_sva.sv
`timescale 1ns/1ps
`include "phf_regs.vh"
// ***
// Halt and clear checks
// ***
module phf_halt_sva (
  input wire        clk_sys,
  input wire        rst,
  input wire        halt_command,
  input wire        fault_clear_command,
  input wire        preset_command,
  input wire [15:0] motion_channel_select,
  input wire [15:0] inhibit_release_option,
  input wire        x_pulse_en,
  input wire        x_stopped_flag,
  input wire        y_stopped_flag,
  input wire        x_homed_flag,
  input wire        operand_fault_flag,
  input wire [15:0] x_fault_code,
  input wire [15:0] y_fault_code
);
  wire [15:0] s = motion_channel_select;
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  halt_x_a: assert property ($rose(halt_command) && s == 0 |=> x_stopped_flag &&
    !x_homed_flag && x_fault_code == `PHF_HALT_CODE) else $error("halt X");
  stop_pulse_a: assert property ($rose(halt_command) && s == 0 |=> !x_pulse_en)
    else $error("pulse kept");
  inhibit_a: assert property (x_stopped_flag |=> !x_pulse_en) else $error("inhibit");
  bad_sel_a: assert property (($rose(halt_command) || $rose(fault_clear_command)) && s > 1
    |=> operand_fault_flag && $stable(x_fault_code) && $stable(y_fault_code)) else $error("sel");
  keep_inh_a: assert property ($rose(fault_clear_command) && !$rose(halt_command) && s == 0
    && inhibit_release_option == 0 |=> x_fault_code == 0 && $stable(x_stopped_flag)) else $error("keep");
  release_a: assert property ($rose(fault_clear_command) && !$rose(halt_command) && s == 1
    && inhibit_release_option != 0 |=> y_fault_code == 0 && !y_stopped_flag) else $error("free");
  once_a: assert property (!$rose(halt_command) && !$rose(fault_clear_command)
    |=> $stable(x_fault_code)) else $error("retrigger");
  preset_a: assert property ($rose(preset_command) && !$rose(halt_command) && s == 0
    |=> x_homed_flag) else $error("preset");
endmodule
bind phf_halt_clear phf_halt_sva u_sva (
  .clk_sys                (clk_sys),
  .rst                    (rst),
  .halt_command           (halt_command),
  .fault_clear_command    (fault_clear_command),
  .preset_command         (preset_command),
  .motion_channel_select  (motion_channel_select),
  .inhibit_release_option (inhibit_release_option),
  .x_pulse_en             (x_pulse_en),
  .x_stopped_flag         (x_stopped_flag),
  .y_stopped_flag         (y_stopped_flag),
  .x_homed_flag           (x_homed_flag),
  .operand_fault_flag     (operand_fault_flag),
  .x_fault_code           (x_fault_code),
  .y_fault_code           (y_fault_code)
);

// >>> phf_regs.vh
// What this block does
// - Halt command rising edge stops pulse output of selected axis at once.
// - Halt sets the selected axis stopped flag.
// - Halt loads fault code 481 into the selected axis.
// - Halt inhibits axis output and clears its homed state.
// - Channel select 0 means axis X, 1 means axis Y.
// - Any other channel select sets operand fault and skips the command.
// - Fault clear rising edge clears the selected axis fault code.
// - Release option zero clears fault code only, inhibit stays.
// - Nonzero 16-bit release option also lifts the output inhibit.
// - Position preset sets the axis homed flag.
`ifndef PHF_REGS_VH
`define PHF_REGS_VH

// ****************************************************************
// Register map
// ****************************************************************
`define PHF_CTRL_OFS      12'h000
`define PHF_CMD_OFS       12'h004
`define PHF_STAT_OFS      12'h008
`define PHF_FAULT_OFS     12'h00C
`define PHF_IRQ_STAT_OFS  12'h010
`define PHF_IRQ_MASK_OFS  12'h014

// ****************************************************************
// Fields and constants
// ****************************************************************
`define PHF_CHAN_X        16'h0000
`define PHF_CHAN_Y        16'h0001
`define PHF_HALT_CODE     16'h01E1
`define PHF_STAT_X_STOP   0
`define PHF_STAT_X_INH    1
`define PHF_STAT_X_HOME   2
`define PHF_STAT_Y_STOP   3
`define PHF_STAT_Y_INH    4
`define PHF_STAT_Y_HOME   5
`define PHF_STAT_OPFLT    6
`define PHF_IRQ_HALT      0
`define PHF_IRQ_CLEAR     1
`define PHF_IRQ_OPFLT     2
`define PHF_CMD_OPFLT_CLR 0

// ****************************************************************
// Reset values and the keep-inhibit release option
// ****************************************************************
`define PHF_FAULT_NONE    16'h0000
`define PHF_INH_KEEP      16'h0000
`define PHF_CTRL_EN_RST   1'b1

`endif

// >>> tb_positioning_halt_and_fault_clear.sv
`timescale 1ns/1ps
`include "phf_regs.vh"
module tb_positioning_halt_and_fault_clear;
  logic        clk_sys = 0, rst = 1, psel = 0, penable = 0, pwrite = 0, er;
  logic        halt_command = 0, fault_clear_command = 0, preset_command = 0;
  logic        x_pulse_req = 1, y_pulse_req = 1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0, rd;
  logic [15:0] motion_channel_select = 16'h0, inhibit_release_option = 16'h0;
  wire  [31:0] prdata;
  wire         pready, pslverr, x_pulse_en, y_pulse_en, x_stopped_flag, y_stopped_flag, irq;
  wire         x_homed_flag, y_homed_flag, operand_fault_flag;
  wire  [15:0] x_fault_code, y_fault_code;
  wire  [31:0] stv = {27'h0, x_stopped_flag, x_homed_flag, y_stopped_flag, y_homed_flag,
                      operand_fault_flag};
  integer      num_errors = 0, checked = 0, i, xs, ys, c0;
  logic [1:0]  rk [7] = '{2, 0, 1, 0, 1, 1, 0};
  logic [15:0] rs [7] = '{0, 0, 0, 1, 1, 0, 2};
  logic [15:0] ro [7] = '{0, 0, 0, 0, 16'hFFFF, 1, 0};
  logic [31:0] re [7] = '{8, 16, 16, 20, 16, 0, 1};
  always #12.5 clk_sys = ~clk_sys;
  phf_halt_clear dut (.clk_sys(clk_sys), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .halt_command(halt_command), .fault_clear_command(fault_clear_command),
    .preset_command(preset_command), .motion_channel_select(motion_channel_select),
    .inhibit_release_option(inhibit_release_option), .x_pulse_req(x_pulse_req),
    .y_pulse_req(y_pulse_req), .x_pulse_en(x_pulse_en), .y_pulse_en(y_pulse_en),
    .x_stopped_flag(x_stopped_flag), .y_stopped_flag(y_stopped_flag),
    .x_homed_flag(x_homed_flag), .y_homed_flag(y_homed_flag),
    .operand_fault_flag(operand_fault_flag), .x_fault_code(x_fault_code),
    .y_fault_code(y_fault_code), .irq(irq));
  phf_drive_model drv (.clk_sys(clk_sys), .x_pulse_en(x_pulse_en), .y_pulse_en(y_pulse_en),
    .x_steps(xs), .y_steps(ys));
  task give_verdict;
    $display("checks %0d errors %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    checked++;
    if (s !== e) begin
      num_errors++;
      $display("Error %s expected %h seen %h", n, e, s);
    end
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    integer n;
    @(posedge clk_sys);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, d};
    @(posedge clk_sys);
    penable <= 1;
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (pready !== 1'b1 && n < 16);
    rd = prdata;
    er = pslverr;
    {psel, penable} <= 2'b00;
    if (n >= 16) begin
      num_errors++;
      give_verdict;
    end else begin
      #1;
    end
  endtask
  task cmd(input logic [1:0] k, input logic [15:0] s, input logic [15:0] o);
    @(posedge clk_sys);
    {motion_channel_select, inhibit_release_option} <= {s, o};
    {halt_command, fault_clear_command, preset_command} <= {k == 0, k == 1, k == 2};
    repeat (2) @(posedge clk_sys);
    {halt_command, fault_clear_command, preset_command} <= 3'b000;
    repeat (2) @(posedge clk_sys);
    #1;
  endtask
  initial begin
    repeat (8) @(posedge clk_sys);
    rst <= 0;
    apb(0, `PHF_CTRL_OFS, 0);
    chk("reset flags", 0, stv);
    chk("ctrl", 1, rd);
    for (i = 0; i < 7; i++) begin
      cmd(rk[i], rs[i], ro[i]);
      chk("flags", re[i], stv);
      chk("codes", {(rk[i] == 0 && rs[i] == 0) ? `PHF_HALT_CODE : 16'h0,
        (rk[i] == 0 && rs[i] == 1) ? `PHF_HALT_CODE : 16'h0}, {x_fault_code, y_fault_code});
    end
    @(posedge clk_sys);
    {halt_command, motion_channel_select} <= {1'b1, 16'h0};
    repeat (2) @(posedge clk_sys);
    #1 c0 = xs;
    repeat (5) @(posedge clk_sys);
    #1 chk("x steps", c0, xs);
    @(posedge clk_sys);
    {fault_clear_command, inhibit_release_option, x_pulse_req} <= {1'b1, 16'h1, 1'b0};
    repeat (4) @(posedge clk_sys);
    #1 chk("held halt", 1, stv);
    @(posedge clk_sys);
    {halt_command, fault_clear_command} <= 2'b00;
    cmd(2, 0, 0);
    @(posedge clk_sys);
    x_pulse_req <= 1;
    repeat (4) @(posedge clk_sys);
    #1 chk("x resumes", 1, {31'h0, xs > c0});
    apb(1, `PHF_CTRL_OFS, 0);
    c0 = ys;
    cmd(0, 1, 0);
    chk("halt disabled", 9, stv);
    chk("y runs", 1, {31'h0, ys > c0});
    apb(1, `PHF_CTRL_OFS, 1);
    cmd(0, 1, 0);
    c0 = ys;
    repeat (3) @(posedge clk_sys);
    #1 chk("y steps", c0, ys);
    chk("halt y", 13, stv);
    apb(0, `PHF_FAULT_OFS, 0);
    chk("fault reg", {`PHF_HALT_CODE, 16'h0}, rd);
    chk("irq masked", 0, {31'h0, irq});
    apb(1, `PHF_IRQ_MASK_OFS, 7);
    chk("irq on", 1, {31'h0, irq});
    apb(1, `PHF_IRQ_STAT_OFS, 7);
    chk("irq clr", 0, {31'h0, irq});
    apb(1, `PHF_CMD_OFS, 1);
    chk("opfault clr", 12, stv);
    apb(0, 12'hFFC, 0);
    chk("unmapped err", 1, {31'h0, er});
    chk("unmapped data", 0, rd);
    give_verdict;
  end
endmodule
